// ==== rtl/uesr_defs.svh ====
// Register offsets, field positions, reset values and event indices for the
// event and shortcut register slice.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
`ifndef UESR_DEFS_SVH
`define UESR_DEFS_SVH

`define UESR_ADDR_W 12
`define UESR_DATA_W 32
`define UESR_OFF_FLOW_ON 12'h100
`define UESR_OFF_FLOW_OFF 12'h104
`define UESR_OFF_RX_READY 12'h108
`define UESR_OFF_TX_DONE 12'h11C
`define UESR_OFF_FAULT 12'h124
`define UESR_OFF_RX_TIMEOUT 12'h144
`define UESR_OFF_LINKS 12'h200
`define UESR_OFF_IRQ_STATUS 12'h300
`define UESR_OFF_IRQ_ENABLE 12'h304
`define UESR_OFF_IRQ_CLEAR 12'h308
`define UESR_RESET_EVENT 1'h0
`define UESR_RESET_LINKS 2'h0
`define UESR_RESET_IRQ 6'h00
`define UESR_LINK_BEGIN_BIT 0
`define UESR_LINK_HALT_BIT 1
`define UESR_EVT_FLOW_ON 0
`define UESR_EVT_FLOW_OFF 1
`define UESR_EVT_RX_READY 2
`define UESR_EVT_TX_DONE 3
`define UESR_EVT_FAULT 4
`define UESR_EVT_RX_TIMEOUT 5
`define UESR_EVT_COUNT 6
`define UESR_CTS_IDLE 1'h1

`endif

// ==== rtl/uesr_pkg.sv ====
// Types shared by the event and shortcut register slice.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package uesr_pkg;
   // Level of the clear-to-send line as seen by the edge finder
   typedef enum logic [1:0] {
      CTS_RESET = 2'b00,
      CTS_LOW = 2'b01,
      CTS_HIGH = 2'b10
   } uesr_cts_type;
endpackage : uesr_pkg

`default_nettype wire

// ==== rtl/uesr_event_flag.sv ====
// One sticky event flag with software write.
// Assumes set and write strobes are one clock long.
`default_nettype none
`include "uesr_defs.svh"

module uesr_event_flag (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Event and software access
   input wire logic eventPulse,
   input wire logic writeEn,
   input wire logic writeBit,
   // Flag value
   output logic flag
);
   logic flag_r;

   // Hardware set wins over a software write of zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flag_r <= `UESR_RESET_EVENT;
      end else if (eventPulse) begin
         flag_r <= 1'b1;
      end else if (writeEn) begin
         flag_r <= writeBit;
      end
   end

   assign flag = flag_r;
endmodule : uesr_event_flag

`default_nettype wire

// ==== rtl/uesr_cts_edge.sv ====
// Finds falling and rising edges of the clear-to-send input.
// Assumes the input is already synchronous to clk_sys.
`default_nettype none
`include "uesr_defs.svh"

module uesr_cts_edge (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Flow-control input, low means clear to send
   input wire logic ctsIn,
   // One-cycle edge pulses
   output logic fellLow,
   output logic roseHigh
);
   uesr_pkg::uesr_cts_type state_r;
   uesr_pkg::uesr_cts_type state_nxt;

   // Next level; first sample after reset only seeds the state
   always_comb begin
      state_nxt = ctsIn ? uesr_pkg::CTS_HIGH : uesr_pkg::CTS_LOW;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= uesr_pkg::CTS_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Edges only between two known levels
   always_comb begin
      fellLow = 1'b0;
      roseHigh = 1'b0;
      case (state_r)
         uesr_pkg::CTS_HIGH: begin
            fellLow = (state_nxt == uesr_pkg::CTS_LOW);
         end
         uesr_pkg::CTS_LOW: begin
            roseHigh = (state_nxt == uesr_pkg::CTS_HIGH);
         end
         default: begin
            fellLow = 1'b0;
         end
      endcase
   end
endmodule : uesr_cts_edge

`default_nettype wire

// ==== rtl/uesr_regs.sv ====
// Event flag and shortcut register slice of a serial transceiver.
// Assumes a single-cycle register port and synchronous event strobes.
// Behaviour
// - Clear-to-send going low sets the flow-on event flag; resets zero.
// - Clear-to-send going high sets the flow-off event flag; resets zero.
// - A byte placed in the receive holding register sets rx-ready flag.
// - Shortcut register links events to tasks without software; resets zero.
// - Link bit 0 set: flow-on event fires the receiver begin task.
// - Link bit 1 set: flow-off event fires the receiver halt task.
`default_nettype none
`include "uesr_defs.svh"

module uesr_regs #(
   parameter int ADDR_W = `UESR_ADDR_W,
   parameter int DATA_W = `UESR_DATA_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [DATA_W-1:0] regRdata,
   // Flow-control pin, low means clear to send
   input wire logic ctsIn,
   // Event strobes from the transceiver core
   input wire logic rxByteStored,
   input wire logic txByteSent,
   input wire logic rxErrorSeen,
   input wire logic rxTimeoutSeen,
   // Task strobes to the receiver
   output logic rx_begin_task,
   output logic rx_halt_task,
   // Interrupt
   output logic irq
);
   localparam int NEV = `UESR_EVT_COUNT;

   logic flowOnPulse;
   logic flowOffPulse;
   logic [NEV-1:0] evtPulse;
   logic [NEV-1:0] evtWrite;
   logic [NEV-1:0] evtFlag;
   logic [1:0] event_task_links_r;
   logic [NEV-1:0] irqStatus_r;
   logic [NEV-1:0] irqEnable_r;
   logic [NEV-1:0] irqClear;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic rxBegin_r;
   logic rxHalt_r;

   // Clear-to-send edge finder
   uesr_cts_edge u_cts (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ctsIn(ctsIn),
      .fellLow(flowOnPulse),
      .roseHigh(flowOffPulse)
   );

   // Event sources in flag order
   always_comb begin
      evtPulse = '0;
      evtPulse[`UESR_EVT_FLOW_ON] = flowOnPulse;
      evtPulse[`UESR_EVT_FLOW_OFF] = flowOffPulse;
      evtPulse[`UESR_EVT_RX_READY] = rxByteStored;
      evtPulse[`UESR_EVT_TX_DONE] = txByteSent;
      evtPulse[`UESR_EVT_FAULT] = rxErrorSeen;
      evtPulse[`UESR_EVT_RX_TIMEOUT] = rxTimeoutSeen;
   end

   // Write decode for each event register
   always_comb begin
      evtWrite = '0;
      if (regWrite && regAddr == `UESR_OFF_FLOW_ON) begin
         evtWrite[`UESR_EVT_FLOW_ON] = 1'b1;
      end else if (regWrite && regAddr == `UESR_OFF_FLOW_OFF) begin
         evtWrite[`UESR_EVT_FLOW_OFF] = 1'b1;
      end else if (regWrite && regAddr == `UESR_OFF_RX_READY) begin
         evtWrite[`UESR_EVT_RX_READY] = 1'b1;
      end else if (regWrite && regAddr == `UESR_OFF_TX_DONE) begin
         evtWrite[`UESR_EVT_TX_DONE] = 1'b1;
      end else if (regWrite && regAddr == `UESR_OFF_FAULT) begin
         evtWrite[`UESR_EVT_FAULT] = 1'b1;
      end else if (regWrite && regAddr == `UESR_OFF_RX_TIMEOUT) begin
         evtWrite[`UESR_EVT_RX_TIMEOUT] = 1'b1;
      end
   end

   // Sticky event flags, one per event
   genvar gi;
   generate
      for (gi = 0; gi < NEV; gi++) begin : g_flag
         uesr_event_flag u_flag (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .eventPulse(evtPulse[gi]),
            .writeEn(evtWrite[gi]),
            .writeBit(regWdata[0]),
            .flag(evtFlag[gi])
         );
      end
   endgenerate

   // Shortcut register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         event_task_links_r <= `UESR_RESET_LINKS;
      end else if (regWrite && regAddr == `UESR_OFF_LINKS) begin
         event_task_links_r <= regWdata[1:0];
      end
   end

   // Shortcut tasks, registered one-cycle strobes
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rxBegin_r <= 1'b0;
         rxHalt_r <= 1'b0;
      end else begin
         rxBegin_r <= flowOnPulse &
            event_task_links_r[`UESR_LINK_BEGIN_BIT];
         rxHalt_r <= flowOffPulse &
            event_task_links_r[`UESR_LINK_HALT_BIT];
      end
   end

   assign rx_begin_task = rxBegin_r;
   assign rx_halt_task = rxHalt_r;

   // Interrupt clear strobe
   always_comb begin
      irqClear = '0;
      if (regWrite && regAddr == `UESR_OFF_IRQ_CLEAR) begin
         irqClear = regWdata[NEV-1:0];
      end
   end

   // Interrupt status: set wins over clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqStatus_r <= `UESR_RESET_IRQ;
      end else begin
         irqStatus_r <= (irqStatus_r & ~irqClear) | evtPulse;
      end
   end

   // Interrupt enable register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqEnable_r <= `UESR_RESET_IRQ;
      end else if (regWrite && regAddr == `UESR_OFF_IRQ_ENABLE) begin
         irqEnable_r <= regWdata[NEV-1:0];
      end
   end

   assign irq = |(irqStatus_r & irqEnable_r);

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      rdata_nxt = '0;
      if (regAddr == `UESR_OFF_FLOW_ON) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_FLOW_ON];
      end else if (regAddr == `UESR_OFF_FLOW_OFF) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_FLOW_OFF];
      end else if (regAddr == `UESR_OFF_RX_READY) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_RX_READY];
      end else if (regAddr == `UESR_OFF_TX_DONE) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_TX_DONE];
      end else if (regAddr == `UESR_OFF_FAULT) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_FAULT];
      end else if (regAddr == `UESR_OFF_RX_TIMEOUT) begin
         rdata_nxt[0] = evtFlag[`UESR_EVT_RX_TIMEOUT];
      end else if (regAddr == `UESR_OFF_LINKS) begin
         rdata_nxt[1:0] = event_task_links_r;
      end else if (regAddr == `UESR_OFF_IRQ_STATUS) begin
         rdata_nxt[NEV-1:0] = irqStatus_r;
      end else if (regAddr == `UESR_OFF_IRQ_ENABLE) begin
         rdata_nxt[NEV-1:0] = irqEnable_r;
      end
   end

   // Read data held for exactly the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else if (regRead) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= '0;
      end
   end

   assign regRdata = rdata_r;
endmodule : uesr_regs

`default_nettype wire

// ==== testbench/uesr_cts_peer.sv ====
// Remote flow-control peer driving the clear-to-send line.
// Assumes the bench asks for the line level through goLow.
`default_nettype none
module uesr_cts_peer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Request from the bench
   input wire logic goLow,
   // Line to the slice, idle high
   output logic ctsIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Low while clear to send, held high through reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctsIn <= 1'b1;
      end else begin
         ctsIn <= !goLow;
      end
   end
endmodule : uesr_cts_peer
`default_nettype wire

// ==== testbench/uesr_regs_assertions.sv ====
// Port-level checks of the event and shortcut slice.
// Assumes it is bound to uesr_regs and sees only its ports.
`default_nettype none
module uesr_regs_assertions #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 32
) (
   // Clock, reset and register port
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [DATA_W-1:0] regRdata,
   // Flow line and event strobes
   input wire logic ctsIn,
   input wire logic rxByteStored,
   input wire logic txByteSent,
   input wire logic rxErrorSeen,
   input wire logic rxTimeoutSeen,
   // Outputs watched
   input wire logic rx_begin_task,
   input wire logic rx_halt_task,
   input wire logic irq
);
   logic [5:0] enable_r;
   logic [1:0] links_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Shadows of the interrupt enable and link registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         enable_r <= 6'h00;
         links_r <= 2'h0;
      end else if (regWrite && regAddr == 12'h304) begin
         enable_r <= regWdata[5:0];
      end else if (regWrite && regAddr == 12'h200) begin
         links_r <= regWdata[1:0];
      end
   end
   AST_FLOW_ON_IRQ: assert property (
      $fell(ctsIn) && !$past(sys_rst) && !regWrite && enable_r[0] |=> irq)
      else $error("flow-on event did not raise irq");
   AST_FLOW_OFF_IRQ: assert property (
      $rose(ctsIn) && !$past(sys_rst) && !regWrite && enable_r[1] |=> irq)
      else $error("flow-off event did not raise irq");
   AST_RX_READY_IRQ: assert property (
      rxByteStored && !regWrite && enable_r[2] |=> irq)
      else $error("rx-ready event did not raise irq");
   AST_LINK_GATE: assert property (
      rx_begin_task |-> $past(links_r[0]) || $past(links_r[0], 2))
      else $error("begin task without its link bit");
   AST_BEGIN_FIRE: assert property (
      $fell(ctsIn) && !$past(sys_rst) && links_r[0] |-> ##[1:2] rx_begin_task)
      else $error("begin task missing after flow-on");
   AST_HALT_FIRE: assert property (
      $rose(ctsIn) && !$past(sys_rst) && links_r[1] |-> ##[1:2] rx_halt_task)
      else $error("halt task missing after flow-off");
   AST_LINK_READBACK: assert property (
      regRead && regAddr == 12'h200 |=> regRdata == {30'h0, links_r})
      else $error("link register read back wrong");
   AST_FLAG_HOLD: assert property (
      (irq && !regWrite) or ((txByteSent || rxErrorSeen || rxTimeoutSeen)
      && !regWrite && enable_r[5:3] == 3'h7) |=> irq)
      else $error("irq dropped or not raised without a write");
endmodule : uesr_regs_assertions
bind uesr_regs uesr_regs_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   uesr_regs_assertions_inst (.clk_sys, .sys_rst, .regAddr, .regWdata,
   .regWrite, .regRead, .regRdata, .ctsIn, .rxByteStored, .txByteSent,
   .rxErrorSeen,
   .rxTimeoutSeen, .rx_begin_task, .rx_halt_task, .irq);
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the event and shortcut register slice.
// Assumes the slice, its checker and the flow peer are compiled first.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWdata = 32'h00000000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic goLow = 1'b0;
   logic [3:0] evt = 4'h0;
   logic [31:0] regRdata;
   logic ctsIn, rx_begin_task, rx_halt_task, irq;
   logic [1:0] seen;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   // Flow peer and slice
   uesr_cts_peer uesr_cts_peer_inst (.clk_sys, .sys_rst, .goLow, .ctsIn);
   uesr_regs uesr_regs_inst (.clk_sys, .sys_rst, .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .ctsIn, .rxByteStored(evt[3]),
      .txByteSent(evt[2]), .rxErrorSeen(evt[1]), .rxTimeoutSeen(evt[0]),
      .rx_begin_task, .rx_halt_task, .irq);
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : chk
   // One-cycle register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr
   // One-cycle register read, data checked in the following cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk($sformatf("read %h", a), exp, regRdata);
   endtask : rd
   // Moves the flow line and gathers task pulses for four cycles
   task automatic cts(input logic low);
      seen = 2'b00;
      @(posedge clk_sys);
      goLow <= low;
      repeat (4) begin
         @(posedge clk_sys);
         #1 seen = seen | {rx_halt_task, rx_begin_task};
      end
   endtask : cts
   // Reset values, unmapped place included
   task automatic t_reset;
      logic [11:0] offs [10] = '{12'h100, 12'h104, 12'h108, 12'h11C,
         12'h124, 12'h144, 12'h200, 12'h300, 12'h304, 12'h400};
      foreach (offs[i]) rd(offs[i], 32'h00000000);
      chk("irq", 32'h00000000, {31'h0, irq});
   endtask : t_reset
   // Links on: flow edges fire tasks and set flags
   task automatic t_links;
      wr(12'h200, 32'h00000003);
      rd(12'h200, 32'h00000003);
      wr(12'h304, 32'h0000003F);
      cts(1'b1);
      chk("task pulses", 32'h00000001, {30'h0, seen});
      rd(12'h100, 32'h00000001);
      cts(1'b0);
      chk("task pulses", 32'h00000002, {30'h0, seen});
      rd(12'h104, 32'h00000001);
   endtask : t_links
   // Core strobes, status, clear and software write of a flag
   task automatic t_events;
      @(posedge clk_sys);
      evt <= 4'hF;
      @(posedge clk_sys);
      evt <= 4'h0;
      rd(12'h108, 32'h00000001);
      rd(12'h11C, 32'h00000001);
      rd(12'h124, 32'h00000001);
      rd(12'h144, 32'h00000001);
      rd(12'h300, 32'h0000003F);
      chk("irq", 32'h00000001, {31'h0, irq});
      wr(12'h308, 32'h0000003F);
      rd(12'h300, 32'h00000000);
      chk("irq", 32'h00000000, {31'h0, irq});
      wr(12'h108, 32'h00000000);
      rd(12'h108, 32'h00000000);
      // Strobe and software clear in one cycle: the set wins
      @(posedge clk_sys);
      evt <= 4'h8;
      regWrite <= 1'b1;
      regAddr <= 12'h108;
      regWdata <= 32'h00000000;
      @(posedge clk_sys);
      evt <= 4'h0;
      regWrite <= 1'b0;
      rd(12'h108, 32'h00000001);
      rd(12'h308, 32'h00000000);
   endtask : t_events
   // Links off and interrupt masked: no task, no irq
   task automatic t_no_link;
      wr(12'h200, 32'h00000000);
      wr(12'h304, 32'h00000000);
      cts(1'b1);
      chk("task pulses", 32'h00000000, {30'h0, seen});
      chk("irq", 32'h00000000, {31'h0, irq});
      cts(1'b0);
      chk("task pulses", 32'h00000000, {30'h0, seen});
   endtask : t_no_link
   // Verdict and end of run
   task automatic end_of_test;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // Clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_links();
      t_events();
      t_no_link();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
